// ---- include/orw_pkg.sv ----
// constants and types for the obd request and wakeup control block
package orw_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam logic [15:0] RSP_TIMEOUT_MS = 16'd200;
  localparam logic [15:0] WAKE_INTERVAL_MS = 16'd3000;
  localparam logic [15:0] SLOW_INIT_MS = 16'd2500;
  localparam logic [15:0] FAST_INIT_MS = 16'd50;
  localparam logic [15:0] DOT_MS = 16'd800;
  localparam int unsigned MAX_REQ_BYTES = 7;
  localparam int unsigned MAX_WAKE_BYTES = 6;
  localparam logic [7:0] CR_CHAR = 8'h0d;
  localparam logic [2:0] PROTO_ISO9141 = 3'd3;
  localparam logic [2:0] PROTO_KWP_SLOW = 3'd4;
  localparam logic [2:0] PROTO_KWP_FAST = 3'd5;
  localparam logic [3:0] PROTO_CAN_MIN = 4'd6;
  localparam logic [47:0] WAKE_ISO9141_DEF = 48'h686af1010000;
  localparam logic [2:0] WAKE_ISO9141_LEN = 3'd5;
  localparam logic [47:0] WAKE_KWP_DEF = 48'hc133f13e0000;
  localparam logic [2:0] WAKE_KWP_LEN = 3'd4;
  // status codes put out on the report port
  localparam logic [2:0] RPT_NONE = 3'd0;
  localparam logic [2:0] RPT_NO_DATA = 3'd1;
  localparam logic [2:0] RPT_INIT_HDR = 3'd2;
  localparam logic [2:0] RPT_INIT_DOT = 3'd3;
  localparam logic [2:0] RPT_INIT_OK = 3'd4;
  localparam logic [2:0] RPT_INIT_ERR = 3'd5;
  localparam logic [2:0] RPT_BAD_REQ = 3'd6;
  typedef enum logic [2:0] {
    ORW_IDLE = 3'b000,
    ORW_INIT = 3'b001,
    ORW_SEND = 3'b010,
    ORW_WAIT = 3'b011,
    ORW_WAKE = 3'b100,
    ORW_WDRAIN = 3'b101
  } orw_state_t;
endpackage : orw_pkg

// ---- verilog/orw_tick.sv ----
// millisecond enable divider
`timescale 1ns/1ps
module orw_tick #(
  parameter int unsigned DIV = 25000  // cycles per enable
) (
  input wire logic mclk,  // system clock
  input wire logic sys_rst,  // sync reset
  output logic tick  // one-cycle pulse per period
);
  logic [15:0] cnt_reg;  // cycle counter
  logic [15:0] cnt_next;
  // wrap at the divide count
  always_comb begin
    cnt_next = (cnt_reg == 16'(DIV - 1)) ? 16'h0000 : cnt_reg + 16'h0001;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  assign tick = (cnt_reg == 16'(DIV - 1));
endmodule : orw_tick

// ---- verilog/orw_wake_mem.sv ----
// wakeup message store, registered read
`timescale 1ns/1ps
module orw_wake_mem #(
  parameter int unsigned DEPTH = 6  // bytes held
) (
  input wire logic mclk,  // system clock
  input wire logic wr_en,  // write strobe
  input wire logic [2:0] wr_addr,  // write index
  input wire logic [7:0] wr_data,  // byte to store
  input wire logic [2:0] rd_addr,  // read index
  output logic [7:0] rd_data  // registered byte
);
  logic [7:0] mem [DEPTH];  // byte array
  // plain ram, no reset: rewritten only while idle, every cycle, at index idle_reg[2:0] mod 6
  always_ff @(posedge mclk) begin
    if (wr_en && (wr_addr < 3'(DEPTH))) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= (rd_addr < 3'(DEPTH)) ? mem[rd_addr] : 8'h00;
  end
endmodule : orw_wake_mem

// ---- verilog/orw_ctrl.sv ----
// request sequencing, bus initiation and wakeup control
`timescale 1ns/1ps
// Functional notes
// R01: wait per response timeout; none gives no-data
// R02: response timeout defaults to 200 ms
// R03: trailing digit caps response count
// R04: timer still runs when count given
// R05: host gives count only when known
// R06: host spaces old-car requests 100 ms
// R07: iso protocols initialise bus before use
// R08: host may force fast or slow init
// R09: init status line then ok or error
// R10: dots only during slow initialisation
// R11: no init status during auto search
// R12: bus traffic at least every five seconds; code does not cap the wakeup interval, up to 65535 ms
// R13: wakeup after idle interval, default 3 s
// R14: default wakeup bytes per protocol plus checksum
// R15: wakeup replies never forwarded
// R16: host wakeup without checksum; device appends it
// R17: host always gives full wakeup message
// R18: wakeup length one to six bytes
// R19: no wakeup messages on can protocols
// R20: each response restarts response timeout
// R21: carriage return only terminates request
// R22: request or response restarts wakeup idle
module orw_ctrl
  import orw_pkg::*;
#(
  parameter int unsigned MS_DIV = orw_pkg::MS_CYCLES  // cycles per ms tick
) (
  input wire logic mclk,  // 25 MHz clock
  input wire logic sys_rst,  // sync reset, high
  input wire logic host_valid,  // host nibble or cr strobe
  input wire logic [7:0] host_char,  // ascii from host
  input wire logic [2:0] protocol_sel,  // active protocol number
  input wire logic auto_search,  // auto search in progress
  input wire logic [7:0] response_timeout_setting,  // 4 ms units, 0 = default
  input wire logic [15:0] wakeup_interval_setting,  // ms, 0 = default
  input wire logic wakeup_message_setting,  // load wakeup bytes pulse
  input wire logic [47:0] wm_bytes,  // wakeup bytes, first in msb
  input wire logic [2:0] wm_len,  // wakeup length
  input wire logic fast_bus_init_command,  // force fast init pulse
  input wire logic slow_bus_init_command,  // force slow init pulse
  input wire logic init_result_ok,  // init outcome from bus phy
  input wire logic rx_msg,  // matching response received pulse
  input wire logic tx_ready,  // bus transmitter accepts a byte
  output logic tx_valid,  // byte offered to bus
  output logic [7:0] tx_byte,  // byte to bus
  output logic tx_last,  // last byte of frame
  output logic rx_forward,  // forward responses to host
  output logic [2:0] report_code,  // status report code
  output logic report_valid,  // report strobe
  output logic busy  // no prompt while high
);
  import orw_pkg::*;
  logic tick;  // 1 ms enable
  logic [7:0] rd_data;  // wakeup byte read
  orw_state_t st_reg, st_next;  // main state
  logic [63:0] req_reg, req_next;  // request nibbles, newest low
  logic [3:0] nib_reg, nib_next;  // nibbles collected
  logic [3:0] cnt_reg, cnt_next;  // bytes to send / index
  logic [3:0] max_reg, max_next;  // response cap, 0 = none
  logic [3:0] got_reg, got_next;  // responses received
  logic [15:0] tmr_reg, tmr_next;  // ms timer
  logic [15:0] idle_reg, idle_next;  // wakeup idle ms
  logic [15:0] dot_reg, dot_next;  // dot pacing ms
  logic slow_reg, slow_next;  // current init is slow
  logic live_reg, live_next;  // bus initialised
  logic [7:0] sum_reg, sum_next;  // checksum accumulator
  logic [2:0] wlen_reg, wlen_next;  // wakeup length
  logic wcus_reg, wcus_next;  // custom wakeup loaded
  logic [47:0] wmb_reg, wmb_next;  // host wakeup bytes, first in msb
  logic [2:0] wr_addr;  // store index
  logic [7:0] wr_data;  // store byte
  logic wr_en;  // store strobe
  logic [2:0] rd_addr;  // read index
  logic [3:0] hexv;  // decoded nibble
  logic ishex;  // char is hex digit
  logic iso;  // iso protocol selected
  logic [15:0] rto_ms;  // response timeout in ms
  logic [15:0] wint_ms;  // wakeup interval in ms
  logic [3:0] nbytes;  // whole bytes in request
  logic want_init;  // init needed
  orw_tick #(.DIV(MS_DIV)) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick(tick)
  );
  // wakeup bytes live in a small store; default picked per protocol
  orw_wake_mem #(.DEPTH(MAX_WAKE_BYTES)) u_mem (
    .mclk(mclk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );
  // decode ascii hex
  always_comb begin
    ishex = 1'b1;
    hexv = 4'h0;
    if (host_char >= 8'h30 && host_char <= 8'h39) begin
      hexv = 4'(host_char - 8'h30);
    end else if (host_char >= 8'h41 && host_char <= 8'h46) begin
      hexv = 4'(host_char - 8'h37);
    end else if (host_char >= 8'h61 && host_char <= 8'h66) begin
      hexv = 4'(host_char - 8'h57);
    end else begin
      ishex = 1'b0;
    end
  end
  assign iso = (protocol_sel == PROTO_ISO9141) || (protocol_sel == PROTO_KWP_SLOW)
    || (protocol_sel == PROTO_KWP_FAST);
  // R02 default timeout when setting is zero
  assign rto_ms = (response_timeout_setting == 8'h00) ? RSP_TIMEOUT_MS
    : {6'h00, response_timeout_setting, 2'b00};
  // R13 default interval when setting is zero
  assign wint_ms = (wakeup_interval_setting == 16'h0000) ? WAKE_INTERVAL_MS
    : wakeup_interval_setting;
  assign nbytes = {1'b0, nib_reg[3:1]};
  assign want_init = iso && !live_reg;
  // store write: host bytes once loaded, else the protocol default
  always_comb begin
    wr_en = 1'b0;
    wr_addr = 3'd0;
    wr_data = 8'h00;
    if (st_reg == ORW_IDLE) begin
      wr_en = 1'b1;
      wr_addr = 3'(idle_reg[2:0] % 3'd6);
      wr_data = wcus_reg ? wmb_reg[8'(47 - 8 * wr_addr) -: 8]
        : (protocol_sel == PROTO_ISO9141)
        ? WAKE_ISO9141_DEF[8'(47 - 8 * wr_addr) -: 8]
        : WAKE_KWP_DEF[8'(47 - 8 * wr_addr) -: 8];
    end
  end
  // read one ahead: the registered byte must stand while the bus stalls
  assign rd_addr = cnt_next[2:0] - 3'd1;
  // main sequencing
  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    nib_next = nib_reg;
    cnt_next = cnt_reg;
    max_next = max_reg;
    got_next = got_reg;
    tmr_next = tmr_reg;
    dot_next = dot_reg;
    slow_next = slow_reg;
    live_next = live_reg;
    sum_next = sum_reg;
    wlen_next = wlen_reg;
    wcus_next = wcus_reg;
    wmb_next = wmb_reg;
    idle_next = (tick && idle_reg != 16'hffff) ? idle_reg + 16'h0001 : idle_reg;
    tx_valid = 1'b0;
    tx_byte = 8'h00;
    tx_last = 1'b0;
    report_valid = 1'b0;
    report_code = RPT_NONE;
    if (!wcus_reg) begin
      wlen_next = (protocol_sel == PROTO_ISO9141) ? WAKE_ISO9141_LEN : WAKE_KWP_LEN;
    end
    // R16 load host wakeup, length checked
    // R18 one to six bytes accepted
    // load after the default so the host length wins
    if (wakeup_message_setting && wm_len != 3'd0 && wm_len <= 3'(MAX_WAKE_BYTES)) begin
      wcus_next = 1'b1;
      wlen_next = wm_len;
      wmb_next = wm_bytes;
    end
    case (st_reg)
      ORW_IDLE: begin
        // R08 forced initialisation accepted only while idle
        if (fast_bus_init_command || slow_bus_init_command) begin
          slow_next = slow_bus_init_command;
          st_next = ORW_INIT;
          tmr_next = 16'h0000;
          dot_next = 16'h0000;
          nib_next = 4'h0;
          // R09 status header unless searching
          // R11 silent during auto search
          report_valid = !auto_search;
          report_code = RPT_INIT_HDR;
        end else if (host_valid && host_char == CR_CHAR) begin
          // R21 cr ends request, never sent
          if (nib_reg == 4'h0) begin
            st_next = ORW_IDLE;
          end else if (nib_reg[0] || nbytes > 4'(MAX_REQ_BYTES)) begin
            // R03 odd nibble is response cap
            max_next = nib_reg[0] ? req_reg[3:0] : 4'h0;
            if (!nib_reg[0] || nbytes == 4'h0) begin
              report_valid = 1'b1;
              report_code = RPT_BAD_REQ;
              nib_next = 4'h0;
            end else begin
              req_next = {4'h0, req_reg[63:4]};
              nib_next = nib_reg - 4'h1;
            end
          end else begin
            max_next = 4'h0;
          end
          if (nib_reg != 4'h0 && !(report_valid)) begin
            // R07 init deferred until a request
            if (want_init) begin
              slow_next = (protocol_sel != PROTO_KWP_FAST);
              st_next = ORW_INIT;
              tmr_next = 16'h0000;
              dot_next = 16'h0000;
              report_valid = !auto_search;
              report_code = RPT_INIT_HDR;
            end else begin
              st_next = ORW_SEND;
            end
            cnt_next = 4'h0;
            sum_next = 8'h00;
          end
        end else if (host_valid && ishex && nib_reg < 4'd15) begin
          req_next = {req_reg[59:0], hexv};
          nib_next = nib_reg + 4'h1;
        // R12 wakes after wint_ms, which is not capped at five seconds
        // R13 wakeup after idle interval
        // R19 none on can protocols
        end else if (live_reg && iso && idle_reg >= wint_ms) begin
          st_next = ORW_WAKE;
          cnt_next = 4'h0;
          sum_next = 8'h00;
        end
      end
      ORW_INIT: begin
        if (tick) begin
          tmr_next = tmr_reg + 16'h0001;
          dot_next = dot_reg + 16'h0001;
        end
        // R10 dots only for slow init
        if (slow_reg && tick && dot_reg == DOT_MS - 16'h0001) begin
          dot_next = 16'h0000;
          report_valid = !auto_search;
          report_code = RPT_INIT_DOT;
        end
        if (tmr_reg >= (slow_reg ? SLOW_INIT_MS : FAST_INIT_MS)) begin
          live_next = init_result_ok;
          idle_next = 16'h0000;
          report_valid = !auto_search;
          report_code = init_result_ok ? RPT_INIT_OK : RPT_INIT_ERR;
          st_next = (init_result_ok && nib_reg != 4'h0) ? ORW_SEND : ORW_IDLE;
          if (!init_result_ok) begin
            nib_next = 4'h0;
          end
        end
      end
      ORW_SEND: begin
        tx_valid = 1'b1;
        if (cnt_reg == nbytes) begin
          tx_byte = sum_reg;
          tx_last = 1'b1;
        end else begin
          tx_byte = req_reg[8'(8 * (nbytes - cnt_reg) - 1) -: 8];
        end
        if (tx_ready) begin
          sum_next = sum_reg + tx_byte;
          cnt_next = cnt_reg + 4'h1;
          if (tx_last) begin
            // R04 timer starts after send
            // R22 request restarts idle count
            st_next = ORW_WAIT;
            tmr_next = 16'h0000;
            got_next = 4'h0;
            idle_next = 16'h0000;
            nib_next = 4'h0;
          end
        end
      end
      ORW_WAIT: begin
        if (tick) begin
          tmr_next = tmr_reg + 16'h0001;
        end
        if (rx_msg) begin
          // R20 each response restarts timer
          tmr_next = 16'h0000;
          idle_next = 16'h0000;
          got_next = got_reg + 4'h1;
          // R03 cap reached ends at once
          if (max_reg != 4'h0 && got_reg + 4'h1 >= max_reg) begin
            st_next = ORW_IDLE;
          end
        end else if (tmr_reg >= rto_ms) begin
          // R01 timeout ends, no-data if none
          st_next = ORW_IDLE;
          report_valid = (got_reg == 4'h0);
          report_code = RPT_NO_DATA;
        end
      end
      ORW_WAKE: begin
        // R14 stored bytes then checksum
        // R16 checksum always appended
        tx_valid = (cnt_reg != 4'h0);
        tx_byte = (cnt_reg > {1'b0, wlen_reg}) ? sum_reg : rd_data;
        tx_last = (cnt_reg > {1'b0, wlen_reg});
        if (cnt_reg == 4'h0) begin
          cnt_next = 4'h1;
        end else if (tx_ready) begin
          sum_next = sum_reg + tx_byte;
          cnt_next = cnt_reg + 4'h1;
          if (tx_last) begin
            st_next = ORW_WDRAIN;
            tmr_next = 16'h0000;
            idle_next = 16'h0000;
          end
        end
      end
      ORW_WDRAIN: begin
        // R15 replies dropped until quiet
        if (tick) begin
          tmr_next = tmr_reg + 16'h0001;
        end
        if (rx_msg) begin
          tmr_next = 16'h0000;
        end else if (tmr_reg >= rto_ms) begin
          st_next = ORW_IDLE;
          idle_next = 16'h0000;
        end
      end
      default: begin
        st_next = ORW_IDLE;
      end
    endcase
    // leaving iso drops the initialised state
    if (!iso) begin
      live_next = 1'b0;
    end
  end
  // register main state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= ORW_IDLE;
      req_reg <= 64'h0;
      nib_reg <= 4'h0;
      cnt_reg <= 4'h0;
      max_reg <= 4'h0;
      got_reg <= 4'h0;
      tmr_reg <= 16'h0000;
      idle_reg <= 16'h0000;
      dot_reg <= 16'h0000;
      slow_reg <= 1'b0;
      live_reg <= 1'b0;
      sum_reg <= 8'h00;
      wlen_reg <= WAKE_KWP_LEN;
      wcus_reg <= 1'b0;
      wmb_reg <= 48'h0;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
      nib_reg <= nib_next;
      cnt_reg <= cnt_next;
      max_reg <= max_next;
      got_reg <= got_next;
      tmr_reg <= tmr_next;
      idle_reg <= idle_next;
      dot_reg <= dot_next;
      slow_reg <= slow_next;
      live_reg <= live_next;
      sum_reg <= sum_next;
      wlen_reg <= wlen_next;
      wcus_reg <= wcus_next;
      wmb_reg <= wmb_next;
    end
  end
  assign rx_forward = (st_reg == ORW_WAIT);
  assign busy = (st_reg != ORW_IDLE);
  // R01 no-data only when nothing came
  no_data_a: assert property (@(posedge mclk) disable iff (sys_rst)
    report_valid && report_code == RPT_NO_DATA |-> got_reg == 4'h0 && st_reg == ORW_WAIT)
    else $error("no-data with responses");
  // R20 response clears timer
  rsp_restart_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_WAIT && rx_msg |=> tmr_reg == 16'h0000)
    else $error("timer not restarted");
  // R15 wakeup replies not forwarded
  wake_hide_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_WDRAIN || st_reg == ORW_WAKE |-> !rx_forward)
    else $error("wakeup reply forwarded");
  // R19 no wakeup on can
  can_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_IDLE && st_next == ORW_WAKE |-> iso)
    else $error("wakeup outside iso");
  // R11 silent during search
  search_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_INIT && auto_search |-> !report_valid)
    else $error("init status in search");
  // R10 no dots on fast init
  fast_nodot_a: assert property (@(posedge mclk) disable iff (sys_rst)
    report_valid && report_code == RPT_INIT_DOT |-> slow_reg)
    else $error("dot on fast init");
  // R22 send clears idle count
  idle_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_SEND && st_next == ORW_WAIT |=> idle_reg == 16'h0000 && st_reg == ORW_WAIT)
    else $error("idle not cleared");
  // R03 cap ends wait
  cap_end_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_WAIT && rx_msg && max_reg != 4'h0 && got_reg + 4'h1 >= max_reg
    |=> st_reg == ORW_IDLE)
    else $error("cap ignored");
  // R16 wakeup frame ends with checksum
  wake_sum_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_reg == ORW_WAKE && tx_last |-> tx_byte == sum_reg
    && cnt_reg == {1'b0, wlen_reg} + 4'h1)
    else $error("wakeup checksum missing");
endmodule : orw_ctrl

// ---- testbench/orw_ecu_model.sv ----
// vehicle ecu model: takes frames with stalls, answers with replies
`timescale 1ns/1ps
module orw_ecu_model (
  input wire logic mclk,  // system clock
  input wire logic sys_rst,  // sync reset, high
  input wire logic tx_valid,  // byte offered by block
  input wire logic [7:0] tx_byte,  // offered byte
  input wire logic tx_last,  // checksum byte marker
  input wire logic [3:0] n_replies,  // replies to give per frame
  input wire logic init_ok,  // outcome of next bus init
  output logic tx_ready,  // byte accepted this cycle
  output logic rx_msg,  // one matching reply
  output logic init_result_ok  // init outcome to block
);
  logic [7:0] frm [0:7];  // last frame seen, checksum included
  int frm_len;  // bytes in last frame
  int frames;  // frames completed so far
  int idx;  // fill index
  int left;  // replies still owed
  int gap;  // cycles to next reply

  // a real ecu decides the init result on its own
  assign init_result_ok = init_ok;

  // accept every other cycle so the offered byte must stand
  always @(posedge mclk) begin
    if (sys_rst) begin
      tx_ready <= 1'b0;
      rx_msg <= 1'b0;
      idx = 0;
      frames = 0;
      frm_len = 0;
      left = 0;
      gap = 0;
    end else begin
      tx_ready <= ~tx_ready;
      rx_msg <= 1'b0;
      // replies spaced so each one is seen apart
      if (left > 0) begin
        if (gap == 0) begin
          rx_msg <= 1'b1;
          left = left - 1;
          gap = 30;
        end else begin
          gap = gap - 1;
        end
      end
      if (tx_valid && tx_ready) begin
        frm[idx[2:0]] = tx_byte;
        idx = idx + 1;
        // frame closed: schedule the replies
        if (tx_last) begin
          frm_len = idx;
          frames = frames + 1;
          idx = 0;
          left = n_replies;
          gap = 30;
        end
      end
    end
  end
endmodule : orw_ecu_model

// ---- testbench/obd_request_wakeup_control_test.sv ----
// self-checking bench for the request, init and wakeup controller
`timescale 1ns/1ps
module obd_request_wakeup_control_test;
  import orw_pkg::*;
  localparam int DIV = 10;  // shortened ms tick
  localparam int TMO = 200 * DIV;  // default response timeout in cycles
  logic mclk = 1'b0;  // 25 MHz clock
  logic sys_rst = 1'b1;  // reset held at start
  logic host_valid = 1'b0, auto_search = 1'b0, wms = 1'b0, fbi = 1'b0, sbi = 1'b0;
  logic [7:0] host_char = 8'h00, rts = 8'h00;  // char and timeout setting
  logic [2:0] protocol_sel = 3'h6, wm_len = 3'h0;  // start on a can protocol
  logic [15:0] wis = 16'h0014;  // 20 ms wakeup interval keeps runs short
  logic [47:0] wm_bytes = 48'h0;  // custom wakeup bytes, loaded by the last test
  logic [3:0] n_replies = 4'h0;  // replies the ecu gives
  logic init_ok = 1'b1;  // ecu init outcome
  logic tx_valid, tx_last, rx_forward, report_valid, busy, tx_ready, rx_msg, init_result_ok;
  logic [7:0] tx_byte;  // byte to bus
  logic [2:0] report_code;  // status code
  int bad_count = 0, samples_checked = 0, fwd_seen = 0;  // tallies
  int rpt_cnt [0:7];  // reports seen by code

  // free-running clock
  initial forever #20 mclk = ~mclk;

  orw_ctrl #(.MS_DIV(DIV)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .host_valid(host_valid),
    .host_char(host_char), .protocol_sel(protocol_sel), .auto_search(auto_search),
    .response_timeout_setting(rts), .wakeup_interval_setting(wis),
    .wakeup_message_setting(wms), .wm_bytes(wm_bytes), .wm_len(wm_len),
    .fast_bus_init_command(fbi), .slow_bus_init_command(sbi),
    .init_result_ok(init_result_ok), .rx_msg(rx_msg), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last), .rx_forward(rx_forward),
    .report_code(report_code), .report_valid(report_valid), .busy(busy));
  orw_ecu_model i_ecu (.mclk(mclk), .sys_rst(sys_rst), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last), .n_replies(n_replies), .init_ok(init_ok),
    .tx_ready(tx_ready), .rx_msg(rx_msg), .init_result_ok(init_result_ok));

  // tally report strobes and forwarding cycles
  always @(posedge mclk) begin
    if (report_valid === 1'b1) rpt_cnt[report_code]++;
    if (rx_forward === 1'b1) fwd_seen++;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task clr;
    for (int i = 0; i < 8; i++) rpt_cnt[i] = 0;
    fwd_seen = 0;
  endtask : clr

  // one-cycle strobe, then a quiet cycle
  task send_char(input logic [7:0] c);
    @(negedge mclk);
    host_valid = 1'b1;
    host_char = c;
    @(negedge mclk);
    host_valid = 1'b0;
  endtask : send_char

  task send_req(input string s);
    for (int i = 0; i < s.len(); i++) send_char(s[i]);
    send_char(CR_CHAR);
  endtask : send_req

  task pulse_init(input logic slow);
    @(negedge mclk);
    if (slow) sbi = 1'b1;
    else fbi = 1'b1;
    @(negedge mclk);
    sbi = 1'b0;
    fbi = 1'b0;
  endtask : pulse_init

  // bounded waits; running out is a mismatch
  task wait_idle(input int lim, output int cyc);
    cyc = 0;
    while (busy !== 1'b0) begin
      @(negedge mclk);
      cyc++;
      if (cyc > lim) begin
        check("busy release", 1, 0);
        tally_and_finish;
      end
    end
  endtask : wait_idle

  task wait_frame(input int lim, output int cyc);
    int f0;
    f0 = i_ecu.frames;
    cyc = 0;
    while (i_ecu.frames == f0) begin
      @(negedge mclk);
      cyc++;
      if (cyc > lim) begin
        check("frame arrival", 1, 0);
        tally_and_finish;
      end
    end
  endtask : wait_frame

  // payload bytes first-in at the msb, then the mod-256 sum
  task check_frame(input string name, input logic [47:0] b, input int len);
    logic [7:0] s;
    s = 8'h00;
    check({name, " len"}, i_ecu.frm_len, len + 1);
    for (int i = 0; i < len; i++) begin
      check(name, i_ecu.frm[i], b[47 - 8 * i -: 8]);
      s = s + b[47 - 8 * i -: 8];
    end
    check({name, " sum"}, i_ecu.frm[len], s);
  endtask : check_frame

  initial begin
    int n;
    int f;
    clr;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    // no reply: default timeout, then no-data
    send_req("0105");
    wait_frame(100, n);
    check_frame("req", 48'h010500000000, 2);
    wait_idle(TMO + 100, n);
    check("nodata time", n >= TMO - 10 && n <= TMO + 30, 1);
    check("nodata rpt", rpt_cnt[RPT_NO_DATA], 1);
    // known count of one: ends at the reply
    repeat (100 * DIV) @(negedge mclk);
    clr;
    n_replies = 4'h1;
    send_req("01051");
    wait_frame(100, n);
    check_frame("cap req", 48'h010500000000, 2);
    wait_idle(TMO + 100, n);
    check("cap time", n < 100, 1);
    check("cap rpt", rpt_cnt[RPT_NO_DATA], 0);
    // count given but nothing comes: timer still closes it
    repeat (100 * DIV) @(negedge mclk);
    clr;
    n_replies = 4'h0;
    send_req("01052");
    wait_frame(100, n);
    wait_idle(TMO + 100, n);
    check("cap tmo time", n >= TMO - 10 && n <= TMO + 30, 1);
    check("cap tmo rpt", rpt_cnt[RPT_NO_DATA], 1);
    // two replies, each restarts the timer
    repeat (100 * DIV) @(negedge mclk);
    clr;
    n_replies = 4'h2;
    send_req("0100");
    wait_frame(100, n);
    wait_idle(TMO + 200, n);
    check("multi time", n >= TMO + 50 && n <= TMO + 100, 1);
    check("multi rpt", rpt_cnt[RPT_NO_DATA], 0);
    check("multi fwd", fwd_seen > 0, 1);
    // can protocol: no wakeup traffic
    f = i_ecu.frames;
    repeat (400) @(negedge mclk);
    check("can wake", i_ecu.frames, f);
    // forced fast init that fails
    protocol_sel = 3'h4;
    clr;
    init_ok = 1'b0;
    pulse_init(1'b0);
    wait_idle(2000, n);
    check("fail hdr", rpt_cnt[RPT_INIT_HDR], 1);
    check("fail err", rpt_cnt[RPT_INIT_ERR], 1);
    check("fail ok", rpt_cnt[RPT_INIT_OK], 0);
    // init inside auto search is silent
    clr;
    auto_search = 1'b1;
    init_ok = 1'b1;
    pulse_init(1'b0);
    wait_idle(2000, n);
    f = 0;
    for (int i = 0; i < 8; i++) f += rpt_cnt[i];
    check("auto quiet", f, 0);
    // forced slow init with dots
    auto_search = 1'b0;
    protocol_sel = 3'h3;
    clr;
    pulse_init(1'b1);
    wait_idle(30000, n);
    check("slow hdr", rpt_cnt[RPT_INIT_HDR], 1);
    check("slow dots", rpt_cnt[RPT_INIT_DOT], SLOW_INIT_MS / DOT_MS);
    check("slow ok", rpt_cnt[RPT_INIT_OK], 1);
    // idle bus gets the iso 9141 wakeup, reply kept from host
    clr;
    n_replies = 4'h1;
    wait_frame(400, n);
    check("wake gap", n >= 190 && n <= 240, 1);
    check_frame("wake iso", 48'h686af1010000, 5);
    wait_idle(TMO + 100, n);
    check("wake fwd", fwd_seen, 0);
    // fast init shows no dots; kwp wakeup content
    protocol_sel = 3'h5;
    clr;
    pulse_init(1'b0);
    wait_idle(2000, n);
    check("fast hdr", rpt_cnt[RPT_INIT_HDR], 1);
    check("fast dots", rpt_cnt[RPT_INIT_DOT], 0);
    check("fast ok", rpt_cnt[RPT_INIT_OK], 1);
    wait_frame(400, n);
    check_frame("wake kwp", 48'hc133f13e0000, 4);
    wait_idle(TMO + 100, n);
    // a request and its reply push the next wakeup out
    send_req("01001");
    wait_frame(100, n);
    wait_frame(400, n);
    check("idle restart", n >= 220 && n <= 290, 1);
    check("bus kept awake", n < 5000 * DIV, 1);
    wait_idle(TMO + 100, n);
    // host loads a complete five byte wakeup, headers and data together
    @(negedge mclk);
    wm_bytes = 48'h112233445500;
    wm_len = 3'h5;
    wms = 1'b1;
    @(negedge mclk);
    wms = 1'b0;
    wait_frame(400, n);
    check_frame("wake cus", 48'h112233445500, 5);
    wait_idle(TMO + 100, n);
    tally_and_finish;
  end
endmodule : obd_request_wakeup_control_test
